// ### inc/mfi_pkg.sv
package mfi_pkg;
   // Function codes carried by each configurable input
   localparam logic [7:0] FN_RAMP_HOLD = 8'h0A;
   localparam logic [7:0] FN_UP = 8'h10;
   localparam logic [7:0] FN_DOWN = 8'h11;
   localparam logic [7:0] FN_FAULT_CLEAR = 8'h14;
   localparam logic [7:0] FN_LOOP_BYPASS = 8'h19;
   localparam logic [7:0] FN_LOCKOUT = 8'h1B;
   localparam logic [7:0] FN_TRIM_UP = 8'h1C;
   localparam logic [7:0] FN_TRIM_DOWN = 8'h1D;
   localparam logic [7:0] FN_SAMPLE_HOLD = 8'h1E;
   localparam logic [7:0] FN_EXT_FAULT_BASE = 8'h20;
   localparam logic [3:0] FN_EXT_FAULT_HI = 4'h2;
   // External fault code field layout
   localparam int EF_POL_BIT = 0;
   localparam int EF_WIN_BIT = 1;
   localparam int EF_ACT_LO = 2;
   localparam int EF_VARIANTS = 16;
   // Stop actions
   typedef enum logic [1:0] {
      MFI_ACT_DECEL = 2'b00,
      MFI_ACT_COAST = 2'b01,
      MFI_ACT_ESTOP = 2'b10,
      MFI_ACT_CONT = 2'b11
   } mfi_action_t;
   // Sample-hold interval
   localparam int CLOCK_HZ = 200_000_000;
   localparam int SH_TIME_MS = 100;
   localparam int SH_CYCLES = CLOCK_HZ / 1000 * SH_TIME_MS;
   localparam int SH_CNT_W = 25;
endpackage : mfi_pkg

// ### rtl/mfi_input_logic.sv
// Functional notes
// - Fault clear acts on inactive-to-active edge
// - Fault clear ignored while run asserted
// - No fault latched: clear input does nothing
// - Bypass input active selects open-loop control
// - Lockout inactive blocks all but frequency writes
// - Trim up adds, trim down subtracts level
// - Both or neither trim: reference unchanged
// - Negative trim result clamps to zero
// - Trim only with analog reference source
// - Multiple exclusive functions flag setting conflict
// - Sample after full continuous hold interval
// - Held value stands until next sample
// - Sample-hold covers every analog input
// - Sixteen external-fault codes accepted
// - Code bits: polarity, window, stop action
// - Fault when active (NO) or inactive (NC)
// - Detect always or only while running
// - Decel, coast, fast stop, or alarm only
// - Duplicate external-fault assignment is rejected
module mfi_input_logic
   import mfi_pkg::*;
#(
   parameter int N_INPUTS = 8,
   parameter int FREQ_W = 16,
   parameter int AIN_W = 12,
   parameter int N_AIN = 4,
   parameter int HOLD_CYCLES = SH_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [N_INPUTS-1:0] term_in,
   input wire logic [N_INPUTS*8-1:0] func_code,
   input wire logic run_cmd,
   input wire logic drive_running,
   input wire logic fault_latched,
   input wire logic ref_is_analog,
   input wire logic [FREQ_W-1:0] freq_ref,
   input wire logic [FREQ_W-1:0] trim_level_param,
   input wire logic [N_AIN*AIN_W-1:0] analog_in,
   input wire logic param_write_req,
   input wire logic param_is_freq,
   input wire logic param_permitted,
   output logic fault_clear,
   output logic closed_loop_en,
   output logic param_write_ok,
   output logic [FREQ_W-1:0] freq_out,
   output logic [N_AIN*AIN_W-1:0] analog_out,
   output logic setting_conflict_error,
   output logic ext_fault_dup_error,
   output logic ext_fault_trip,
   output logic ext_decel_stop,
   output logic ext_coast_stop,
   output logic ext_fast_stop,
   output logic ext_alarm,
   output logic [EF_VARIANTS-1:0] ext_fault_active
);
   logic [N_INPUTS-1:0] in_sync;
   logic [1:0] run_pair;
   logic run_s;
   logic running_s;

   // Synchronise terminals and the external run/running levels
   mfi_sync #(.WIDTH(N_INPUTS)) u_sync_term (
      .clock(clock),
      .reset(reset),
      .async_in(term_in),
      .sync_out(in_sync)
   );
   mfi_sync #(.WIDTH(2)) u_sync_run (
      .clock(clock),
      .reset(reset),
      .async_in({run_cmd, drive_running}),
      .sync_out(run_pair[1:0])
   );
   assign run_s = run_pair[1];
   assign running_s = run_pair[0];

   // Per-function level and assignment flags across all inputs
   logic [N_INPUTS-1:0] is_clr;
   logic [N_INPUTS-1:0] is_byp;
   logic [N_INPUTS-1:0] is_lock;
   logic [N_INPUTS-1:0] is_tup;
   logic [N_INPUTS-1:0] is_tdn;
   logic [N_INPUTS-1:0] is_sh;
   logic [N_INPUTS-1:0] is_ramp;
   logic [N_INPUTS-1:0] is_updn;
   logic [N_INPUTS-1:0] is_ef;
   logic [EF_VARIANTS-1:0] ef_assigned;
   logic [EF_VARIANTS-1:0] ef_level;
   logic [EF_VARIANTS-1:0] ef_dup;

   for (genvar i = 0; i < N_INPUTS; i++) begin : g_dec
      wire [7:0] code = func_code[i*8 +: 8];
      assign is_clr[i] = (code == FN_FAULT_CLEAR);
      assign is_byp[i] = (code == FN_LOOP_BYPASS);
      assign is_lock[i] = (code == FN_LOCKOUT);
      assign is_tup[i] = (code == FN_TRIM_UP);
      assign is_tdn[i] = (code == FN_TRIM_DOWN);
      assign is_sh[i] = (code == FN_SAMPLE_HOLD);
      assign is_ramp[i] = (code == FN_RAMP_HOLD);
      assign is_updn[i] = (code == FN_UP) || (code == FN_DOWN);
      assign is_ef[i] = (code[7:4] == FN_EXT_FAULT_HI);
   end

   // Each external-fault variant: assigned, duplicated, and its raw level
   for (genvar v = 0; v < EF_VARIANTS; v++) begin : g_ef
      logic [N_INPUTS-1:0] hit;
      for (genvar i = 0; i < N_INPUTS; i++) begin : g_hit
         assign hit[i] = is_ef[i] && (func_code[i*8 +: 4] == 4'(v));
      end
      assign ef_assigned[v] = |hit;
      assign ef_dup[v] = (hit & (hit - 1'b1)) != '0;
      assign ef_level[v] = |(hit & in_sync);
   end

   // Function group presence and active levels
   wire any_ramp = |is_ramp;
   wire any_updn = |is_updn;
   wire any_trim = |(is_tup | is_tdn);
   wire any_sh = |is_sh;
   wire clr_level = |(is_clr & in_sync);
   wire byp_level = |(is_byp & in_sync);
   wire lock_level = |(is_lock & in_sync);
   wire tup_level = |(is_tup & in_sync);
   wire tdn_level = |(is_tdn & in_sync);
   wire sh_level = |(is_sh & in_sync);
   wire sh_assigned = any_sh;

   // More than one mutually exclusive group assigned
   wire [2:0] grp_cnt = 3'(any_ramp) + 3'(any_updn) + 3'(any_trim) + 3'(any_sh);
   wire conflict = (grp_cnt > 3'h1);
   wire dup_any = |ef_dup;

   // Fault clear: edge detect on the synchronised level
   logic clr_prev_reg;
   logic fault_clear_reg;
   wire clr_rise = clr_level && !clr_prev_reg;
   wire clr_fire = clr_rise && !run_s && fault_latched;

   // Previous clear level; resets to the inactive level so no false edge follows reset
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         clr_prev_reg <= 1'b0;
      end else begin
         clr_prev_reg <= clr_level;
      end
   end

   // One-cycle clear pulse
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         fault_clear_reg <= 1'b0;
      end else begin
         fault_clear_reg <= clr_fire;
      end
   end

   // Control mode and write lockout; unassigned functions keep defaults
   logic closed_loop_reg;
   logic write_ok_reg;
   wire lock_assigned = |is_lock;
   wire lock_open = !lock_assigned || lock_level;
   wire write_allow = lock_open ? param_permitted : param_is_freq;

   // Control mode: open loop while the bypass input is active
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         closed_loop_reg <= 1'b1;
      end else begin
         closed_loop_reg <= !byp_level;
      end
   end

   // Write acceptance, one cycle after the request
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         write_ok_reg <= 1'b0;
      end else begin
         write_ok_reg <= param_write_req && write_allow;
      end
   end

   // Trim arithmetic with zero clamp
   wire trim_add = tup_level && !tdn_level && ref_is_analog;
   wire trim_sub = tdn_level && !tup_level && ref_is_analog;
   wire [FREQ_W:0] sum = {1'b0, freq_ref} + {1'b0, trim_level_param};
   wire under = (trim_level_param > freq_ref);
   wire [FREQ_W-1:0] diff = under ? '0 : freq_ref - trim_level_param;
   wire [FREQ_W-1:0] sat_sum = sum[FREQ_W] ? '1 : sum[FREQ_W-1:0];
   wire [FREQ_W-1:0] freq_next = trim_add ? sat_sum :
                                 trim_sub ? diff : freq_ref;
   logic [FREQ_W-1:0] freq_reg;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         freq_reg <= '0;
      end else begin
         freq_reg <= freq_next;
      end
   end

   // Sample-hold: one timer per analog channel, all driven by the same input
   logic [N_AIN*AIN_W-1:0] ain_held;
   for (genvar a = 0; a < N_AIN; a++) begin : g_sh
      mfi_sample_hold #(.DATA_W(AIN_W), .HOLD_CYCLES(HOLD_CYCLES)) u_sh (
         .clock(clock),
         .reset(reset),
         .hold_in(sh_level),
         .analog_in(analog_in[a*AIN_W +: AIN_W]),
         .analog_held(ain_held[a*AIN_W +: AIN_W]),
         .sampled()
      );
   end
   logic [N_AIN*AIN_W-1:0] analog_reg;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         analog_reg <= '0;
      end else begin
         analog_reg <= sh_assigned ? ain_held : analog_in;
      end
   end

   // External fault detection and stop action
   logic [EF_VARIANTS-1:0] ef_det;
   for (genvar v = 0; v < EF_VARIANTS; v++) begin : g_det
      localparam int VCODE = v;
      localparam bit NC = VCODE[EF_POL_BIT];
      localparam bit RUN_ONLY = VCODE[EF_WIN_BIT];
      wire lvl = ef_level[v] ^ NC;
      wire win = !RUN_ONLY || running_s;
      assign ef_det[v] = ef_assigned[v] && lvl && win && !dup_any;
   end

   logic [3:0] act_hit;
   for (genvar k = 0; k < 4; k++) begin : g_act
      logic [EF_VARIANTS-1:0] sel;
      for (genvar v = 0; v < EF_VARIANTS; v++) begin : g_sel
         assign sel[v] = ((v >> EF_ACT_LO) == k);
      end
      assign act_hit[k] = |(ef_det & sel);
   end

   logic [EF_VARIANTS-1:0] ef_act_reg;
   logic [3:0] act_reg;
   logic conflict_reg;
   logic dup_reg;

   // Per-variant detection flags
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ef_act_reg <= '0;
      end else begin
         ef_act_reg <= ef_det;
      end
   end

   // Stop action levels, registered with the flags so both agree each cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         act_reg <= '0;
      end else begin
         act_reg <= act_hit;
      end
   end

   // Setting conflict level
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         conflict_reg <= 1'b0;
      end else begin
         conflict_reg <= conflict;
      end
   end

   // Duplicate external-fault level
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dup_reg <= 1'b0;
      end else begin
         dup_reg <= dup_any;
      end
   end

   // Control and data outputs
   assign fault_clear = fault_clear_reg;
   assign closed_loop_en = closed_loop_reg;
   assign param_write_ok = write_ok_reg;
   assign freq_out = freq_reg;
   assign analog_out = analog_reg;

   // Configuration error outputs
   assign setting_conflict_error = conflict_reg;
   assign ext_fault_dup_error = dup_reg;

   // External fault outputs
   assign ext_fault_active = ef_act_reg;
   assign ext_decel_stop = act_reg[MFI_ACT_DECEL];
   assign ext_coast_stop = act_reg[MFI_ACT_COAST];
   assign ext_fast_stop = act_reg[MFI_ACT_ESTOP];
   assign ext_alarm = act_reg[MFI_ACT_CONT];
   assign ext_fault_trip = |act_reg[MFI_ACT_ESTOP:MFI_ACT_DECEL];
endmodule : mfi_input_logic

// ### rtl/mfi_sample_hold.sv
module mfi_sample_hold
   import mfi_pkg::*;
#(
   parameter int DATA_W = 12,
   parameter int HOLD_CYCLES = SH_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic hold_in,
   input wire logic [DATA_W-1:0] analog_in,
   output logic [DATA_W-1:0] analog_held,
   output logic sampled
);
   logic [SH_CNT_W-1:0] count_reg;
   logic [DATA_W-1:0] held_reg;
   logic sampled_reg;
   logic done_reg;
   wire reach = (count_reg == SH_CNT_W'(HOLD_CYCLES - 1));

   // Counts continuous active time; a drop restarts the interval
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count_reg <= '0;
         done_reg <= 1'b0;
         held_reg <= '0;
         sampled_reg <= 1'b0;
      end else begin
         sampled_reg <= 1'b0;
         if (!hold_in) begin
            count_reg <= '0;
            done_reg <= 1'b0;
         end else if (!done_reg) begin
            if (reach) begin
               held_reg <= analog_in;
               sampled_reg <= 1'b1;
               done_reg <= 1'b1;
            end else begin
               count_reg <= count_reg + 1'b1;
            end
         end
      end
   end
   assign analog_held = held_reg;
   assign sampled = sampled_reg;
endmodule : mfi_sample_hold

// ### rtl/mfi_sync.sv
module mfi_sync
   import mfi_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // Two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
      end
   end
   assign sync_out = stage2_reg;
endmodule : mfi_sync

// ### tb/mfi_chk.sv
module mfi_chk
   import mfi_pkg::*;
#(
   parameter int FREQ_W = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic run_cmd,
   input wire logic fault_latched,
   input wire logic ref_is_analog,
   input wire logic [FREQ_W-1:0] freq_ref,
   input wire logic param_write_req,
   input wire logic param_is_freq,
   input wire logic param_permitted,
   input wire logic fault_clear,
   input wire logic param_write_ok,
   input wire logic [FREQ_W-1:0] freq_out,
   input wire logic ext_fault_trip,
   input wire logic ext_decel_stop,
   input wire logic ext_coast_stop,
   input wire logic ext_fast_stop,
   input wire logic ext_fault_dup_error,
   input wire logic [EF_VARIANTS-1:0] ext_fault_active
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // Write aimed at a protected parameter
   sequence wr_blocked;
      param_write_req && !param_is_freq && !param_permitted;
   endsequence
   // Clear pulse then a quiet cycle
   sequence clr_pulse;
      fault_clear ##1 !fault_clear;
   endsequence
   chk_clear_pulse: assert property (fault_clear |-> clr_pulse)
      else $error("fault clear longer than one cycle");
   chk_clear_latch: assert property (fault_clear |-> $past(fault_latched))
      else $error("fault clear with no fault latched");
   chk_clear_run: assert property (fault_clear |-> !$past(run_cmd, 3))
      else $error("fault clear while running");
   chk_write_block: assert property (wr_blocked |=> !param_write_ok)
      else $error("protected write accepted");
   chk_write_cause: assert property (param_write_ok |-> $past(param_write_req))
      else $error("write accepted without request");
   chk_trim_off: assert property ($past(!ref_is_analog && !reset) |->
      freq_out == $past(freq_ref))
      else $error("trim applied to non-analog reference");
   chk_trip_sum: assert property (ext_fault_trip ==
      (ext_decel_stop || ext_coast_stop || ext_fast_stop))
      else $error("trip flag disagrees with stop actions");
   chk_decel_code: assert property (ext_decel_stop == (|ext_fault_active[3:0]))
      else $error("decelerate action disagrees with detected codes");
   chk_coast_code: assert property (ext_coast_stop == (|ext_fault_active[7:4]))
      else $error("coast action disagrees with detected codes");
   chk_fast_code: assert property (ext_fast_stop == (|ext_fault_active[11:8]))
      else $error("fast stop action disagrees with detected codes");
   chk_dup_mask: assert property (ext_fault_dup_error && $past(ext_fault_dup_error) |->
      ext_fault_active == '0)
      else $error("detection active under duplicate config");
endmodule : mfi_chk

bind mfi_input_logic mfi_chk #(.FREQ_W(FREQ_W)) u_chk (.clock(clock), .reset(reset),
   .run_cmd(run_cmd), .fault_latched(fault_latched), .ref_is_analog(ref_is_analog),
   .freq_ref(freq_ref), .param_write_req(param_write_req), .param_is_freq(param_is_freq),
   .param_permitted(param_permitted), .fault_clear(fault_clear),
   .param_write_ok(param_write_ok), .freq_out(freq_out), .ext_fault_trip(ext_fault_trip),
   .ext_decel_stop(ext_decel_stop), .ext_coast_stop(ext_coast_stop),
   .ext_fast_stop(ext_fast_stop), .ext_fault_dup_error(ext_fault_dup_error),
   .ext_fault_active(ext_fault_active));

// ### tb/mfi_input_logic_tb.sv
module mfi_input_logic_tb
   import mfi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'h0;
   logic reset = 1'h1;
   logic [7:0] term = 8'h00;
   logic [63:0] fc;
   logic run = 1'h0, lat = 1'h0, ana = 1'h0, wr = 1'h0, isf = 1'h0, perm = 1'h0;
   logic drun = 1'h0, fon = 1'h0, nc = 1'h0, cont;
   logic [11:0] lvl = 12'h000;
   logic [47:0] ain, aout;
   logic [15:0] fref = 16'h0000, trim = 16'h0000, fout, act;
   logic clr, cle, wok, conf, dup, trip, dec, coa, fst, alm;
   logic [7:0] tbl [3];
   integer miscompares = 0, samples_checked = 0, clr_cnt = 0, seed = 32'h960b;
   integer i, k, e;
   // Device under test and field side
   mfi_input_logic #(.N_INPUTS(8), .FREQ_W(16), .AIN_W(12), .N_AIN(4), .HOLD_CYCLES(16)) uut (
      .clock(clock), .reset(reset), .term_in({term[7:6], cont, term[4:0]}), .func_code(fc),
      .run_cmd(run), .drive_running(drun), .fault_latched(lat), .ref_is_analog(ana),
      .freq_ref(fref), .trim_level_param(trim), .analog_in(ain), .param_write_req(wr),
      .param_is_freq(isf), .param_permitted(perm), .fault_clear(clr), .closed_loop_en(cle),
      .param_write_ok(wok), .freq_out(fout), .analog_out(aout), .setting_conflict_error(conf),
      .ext_fault_dup_error(dup), .ext_fault_trip(trip), .ext_decel_stop(dec),
      .ext_coast_stop(coa), .ext_fast_stop(fst), .ext_alarm(alm), .ext_fault_active(act));
   mfi_periph u_periph (.fault_on(fon), .nc_type(nc), .level(lvl), .contact(cont),
      .analog(ain));
   // Clock, pulse counter and watchdog
   initial forever #2.5 clock = ~clock;
   always @(negedge clock) if (clr === 1'h1) clr_cnt++;
   initial begin
      #50000;
      miscompares++;
      close_out();
   end
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic step(input integer n);
      repeat (n) @(negedge clock);
   endtask : step
   task automatic fin(input string n);
      $display("test %s finished", n);
   endtask : fin
   // Pulse the clear input once and count pulses
   task automatic clr_try(input logic r, input logic l, input integer n);
      run = r;
      lat = l;
      step(6);
      clr_cnt = 0;
      term[0] = 1'h1;
      step(3);
      term[0] = 1'h0;
      step(6);
      check("clear", clr_cnt, n);
   endtask : clr_try
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   // Main sequence
   initial begin
      fc = {8'h0F, 8'h0F, FN_EXT_FAULT_BASE, FN_TRIM_DOWN, FN_TRIM_UP, FN_LOCKOUT,
         FN_LOOP_BYPASS, FN_FAULT_CLEAR};
      tbl = '{FN_RAMP_HOLD, FN_UP, FN_SAMPLE_HOLD};
      step(2);
      check("reset loop", cle, 1'h1);
      reset = 1'h0;
      clr_try(1'h1, 1'h1, 0);
      clr_try(1'h0, 1'h1, 1);
      clr_try(1'h0, 1'h0, 0);
      fin("clear");
      for (i = 1; i >= 0; i--) begin
         term[1] = i[0];
         step(4);
         check("loop", cle, !i[0]);
      end
      wr = 1'h1;
      for (i = 0; i < 8; i++) begin
         {term[2], isf, perm} = i[2:0];
         step(5);
         check("write", wok, i[2] ? i[0] : i[1]);
      end
      wr = 1'h0;
      fin("bypass and lockout");
      for (i = 0; i < 24; i++) begin
         k = $random(seed);
         {term[4:3], ana} = k[2:0];
         fref = $random(seed);
         trim = $random(seed);
         step(5);
         e = fref;
         if (ana && term[3] != term[4]) e = term[3] ? e + trim : e - trim;
         if (e < 0) e = 0;
         if (e > 32'hFFFF) e = 32'hFFFF;
         check("trim", fout, e[15:0]);
      end
      fin("trim");
      for (i = 0; i < 64; i++) begin
         fc[47:40] = FN_EXT_FAULT_BASE + i[5:2];
         {nc, drun, fon} = i[2:0];
         step(5);
         k = i[0] && (!i[3] || i[1]);
         e = i[5:4];
         check("ext", act, k ? 16'h1 << i[5:2] : 0);
         check("stop", {trip, dec, coa, fst, alm},
            k ? {e != 3, e == 0, e == 1, e == 2, e == 3} : 0);
      end
      fc[47:40] = FN_EXT_FAULT_BASE;
      fc[63:56] = FN_EXT_FAULT_BASE;
      {nc, fon} = 2'h1;
      step(4);
      check("dup", {dup, act}, 17'h10000);
      fin("external fault");
      for (i = 0; i < 3; i++) begin
         fc[63:56] = tbl[i];
         step(3);
         check("conflict", conf, 1'h1);
      end
      fc = {8'h0F, FN_SAMPLE_HOLD, 8'h0F, 32'h0F0F1B19, FN_FAULT_CLEAR};
      step(3);
      check("no conflict", conf, 1'h0);
      lvl = 12'h111;
      term[6] = 1'h1;
      step(4);
      lvl = 12'h2A5;
      step(24);
      check("held", aout, {12'h2A8, 12'h2A7, 12'h2A6, 12'h2A5});
      lvl = 12'h7C3;
      term[6] = 1'h0;
      step(6);
      check("kept", aout, {12'h2A8, 12'h2A7, 12'h2A6, 12'h2A5});
      term[6] = 1'h1;
      step(8);
      term[6] = 1'h0;
      step(20);
      check("early drop", aout, {12'h2A8, 12'h2A7, 12'h2A6, 12'h2A5});
      term[6] = 1'h1;
      step(24);
      check("resample", aout, {12'h7C6, 12'h7C5, 12'h7C4, 12'h7C3});
      fin("sample hold");
      close_out();
   end
endmodule : mfi_input_logic_tb

// ### tb/mfi_periph.sv
module mfi_periph (
   input wire logic fault_on,
   input wire logic nc_type,
   input wire logic [11:0] level,
   output logic contact,
   output logic [47:0] analog
);
   timeunit 1ns;
   timeprecision 100ps;
   // Contact opens on fault when normally closed
   assign contact = nc_type ? !fault_on : fault_on;
   // Four analog channels: the level, then the level plus 1, 2 and 3
   assign analog = {level + 12'h3, level + 12'h2, level + 12'h1, level};
endmodule : mfi_periph
